//--- rtl/bada_core.sv
// How it works
// (RQ1) RAM and some special registers are reachable as bytes and as single bits
// (RQ2) bit addresses 00h-7Fh map to RAM bytes 20h-2Fh, eight bits each
// (RQ3) special registers at multiples of eight, 80h-F0h, own bit addresses byte+index
// (RQ4) add with carry from register: 1 byte 1 cycle; direct, immediate: 2 bytes 1 cycle
// (RQ5) add immediate without carry: 2 bytes, 1 cycle
// (RQ6) subtract register with borrow from carry: 1 byte, 1 cycle
// (RQ7) increment direct byte: 2 bytes, 1 cycle
// (RQ8) decrement indirect RAM through pointer register: 1 byte, 1 cycle
// (RQ9) increment 16-bit data pointer: 1 byte, 2 cycles
// (RQ10) decimal adjust accumulator: 1 byte, 1 cycle
// (RQ11) AND, OR, XOR immediate into direct byte: 3 bytes, 2 cycles
// (RQ12) AND accumulator into direct byte, result to that byte: 2 bytes, 1 cycle
// (RQ13) OR direct byte into accumulator: 2 bytes, 1 cycle
// (RQ14) XOR immediate into accumulator: 2 bytes, 1 cycle
// (RQ15) complement accumulator: 1 byte, 1 cycle
// (RQ16) rotate left through carry, nine-bit: 1 byte, 1 cycle
// (RQ17) rotate right, bit 0 into bit 7: 1 byte, 1 cycle
// (RQ18) swap accumulator nibbles: 1 byte, 1 cycle
// (RQ19) multiply and divide by aux register: 1 byte, 4 cycles, results in both
// (RQ20) upper area direct means special registers; upper RAM only indirectly
module bada_core (
  // clock and reset
  input  logic               clk_i,
  input  logic               rst_b_i,
  // instruction issue
  input  logic               start_i,
  input  bada_pkg::bada_op_t op_i,
  input  bada_pkg::bada_mode_t mode_i,
  input  logic               dst_mem_i,
  input  logic [2:0]         reg_sel_i,
  input  logic [7:0]         opnd1_i,
  input  logic [7:0]         opnd2_i,
  // bit-address port
  input  logic               bit_re_i,
  input  logic               bit_we_i,
  input  logic [7:0]         bit_addr_i,
  input  logic               bit_val_i,
  // status and results
  output logic               busy_o,
  output logic               done_o,
  output logic [1:0]         len_o,
  output logic [2:0]         cyc_o,
  output logic [7:0]         acc_o,
  output logic [7:0]         b_o,
  output logic [7:0]         psw_o,
  output logic [15:0]        data_pointer_16_o,
  output logic               bit_rd_o
);

  typedef enum logic {ST_IDLE, ST_RUN} bada_state_t;

  bada_state_t          st_q;
  bada_pkg::bada_op_t   op_q;
  bada_pkg::bada_mode_t mode_q;
  logic                 dmem_q;
  logic [2:0]           reg_q;
  logic [7:0]           o1_q;
  logic [7:0]           o2_q;
  logic [2:0]           cnt_q;
  logic [3:0]           div_q;
  logic                 mc_en_q;
  logic                 done_q;
  logic [1:0]           len_q;
  logic [2:0]           cyc_q;
  logic                 par_q;
  logic                 bit_rd_q;
  logic [2:0]           mcs_q;
  logic [7:0]           sfr_q [bada_pkg::NSFR];
  logic [7:0]           ram_q [bada_pkg::RAM_BYTES];

  logic [7:0]  rn_addr, ptr_addr, ptr, dir_val, mem_val, bit_byte, bit_byte_val;
  logic [4:0]  dir_sx, bit_sx, wr_sx;
  logic        ind_ok, ex_fire, start_ok, is_incdec, logic_mem, acc_we, mem_we;
  logic        wr_en, wr_sfr;
  logic [7:0]  wr_addr, wr_data, alu_a, alu_b, alu_res, alu_hi;
  logic        alu_hi_we, alu_cy, alu_cy_we, alu_ac, alu_ac_we, alu_ov, alu_ov_we;
  logic [1:0]  len_d;
  logic [2:0]  cyc_d;
  logic [15:0] data_pointer_16_inc;

  // instruction length in bytes and in machine cycles
  always_comb begin
    len_d = 2'd1;
    cyc_d = 3'd1;
    if (mode_i == bada_pkg::MD_DIR || mode_i == bada_pkg::MD_IMM) begin
      len_d = 2'd2; // RQ4 RQ5 RQ7 RQ12 RQ13 RQ14
    end
    if (dst_mem_i && mode_i == bada_pkg::MD_IMM) begin
      len_d = 2'd3; // RQ11
      cyc_d = 3'd2;
    end
    if (dst_mem_i && mode_i == bada_pkg::MD_ACC) begin
      len_d = 2'd2; // RQ12
    end
    case (op_i)
      bada_pkg::OP_INC_DATA_POINTER_16: begin
        len_d = 2'd1; // RQ9
        cyc_d = 3'd2;
      end
      bada_pkg::OP_MUL, bada_pkg::OP_DIV: begin
        len_d = 2'd1; // RQ19
        cyc_d = 3'd4;
      end
      bada_pkg::OP_DA, bada_pkg::OP_CLR, bada_pkg::OP_CPL, bada_pkg::OP_RL, bada_pkg::OP_RLC,
      bada_pkg::OP_RR, bada_pkg::OP_RRC, bada_pkg::OP_SWAP: begin
        len_d = 2'd1; // RQ10 RQ15 RQ16 RQ17 RQ18
        cyc_d = 3'd1;
      end
      default: begin
      end
    endcase
  end

  // machine-cycle enable from the oscillator clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 4'h0;
      mc_en_q <= 1'b0;
    end else begin
      mc_en_q <= (div_q == bada_pkg::MC_CLKS - 4'h1);
      div_q <= (div_q == bada_pkg::MC_CLKS - 4'h1) ? 4'h0 : div_q + 4'h1;
    end
  end

  assign start_ok = start_i && (st_q == ST_IDLE);
  assign ex_fire = (st_q == ST_RUN) && mc_en_q && (cnt_q == 3'd0);

  // sequencer: latch, wait out the machine cycles, execute on the last
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      op_q <= bada_pkg::OP_ADD;
      mode_q <= bada_pkg::MD_ACC;
      dmem_q <= 1'b0;
      reg_q <= 3'd0;
      o1_q <= 8'h00;
      o2_q <= 8'h00;
      cnt_q <= 3'd0;
      done_q <= 1'b0;
      len_q <= 2'd0;
      cyc_q <= 3'd0;
    end else begin
      done_q <= ex_fire;
      case (st_q)
        ST_IDLE: begin
          if (start_i) begin
            st_q <= ST_RUN;
            op_q <= op_i;
            mode_q <= mode_i;
            {dmem_q, reg_q, o1_q, o2_q} <= {dst_mem_i, reg_sel_i, opnd1_i, opnd2_i};
            cnt_q <= cyc_d - 3'd1;
            len_q <= len_d;
            cyc_q <= cyc_d;
          end
        end
        ST_RUN: begin
          if (ex_fire) begin
            st_q <= ST_IDLE;
          end else if (mc_en_q) begin
            cnt_q <= cnt_q - 3'd1;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // operand addressing: bank register, pointer, direct byte
  always_comb begin
    rn_addr = {3'b000, sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_RS1:bada_pkg::PSW_RS0], reg_q};
    ptr_addr = {3'b000, sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_RS1:bada_pkg::PSW_RS0], 2'b00, reg_q[0]};
    ptr = ram_q[ptr_addr];
    ind_ok = (ptr <= bada_pkg::RAM_TOP); // RQ20
    dir_sx = bada_pkg::sfr_index(o1_q);
    if (!o1_q[7]) begin
      dir_val = ram_q[o1_q]; // RQ20
    end else if (!dir_sx[4]) begin
      dir_val = 8'h00;
    end else if (dir_sx[3:0] == bada_pkg::IDX_PSW) begin
      dir_val = {sfr_q[bada_pkg::IDX_PSW][7:1], par_q};
    end else begin
      dir_val = sfr_q[dir_sx[3:0]];
    end
  end

  // source operand by addressing mode
  always_comb begin
    case (mode_q)
      bada_pkg::MD_REG: mem_val = ram_q[rn_addr];
      bada_pkg::MD_DIR: mem_val = dir_val;
      bada_pkg::MD_IND: mem_val = ind_ok ? ram_q[ptr] : 8'h00; // RQ8 RQ20
      bada_pkg::MD_IMM: mem_val = o1_q;
      default: mem_val = sfr_q[bada_pkg::IDX_ACC];
    endcase
  end

  // alu inputs and destination selection
  always_comb begin
    is_incdec = (op_q == bada_pkg::OP_INC) || (op_q == bada_pkg::OP_DEC);
    logic_mem = dmem_q && (op_q == bada_pkg::OP_ANL || op_q == bada_pkg::OP_ORL || op_q == bada_pkg::OP_XRL);
    alu_a = sfr_q[bada_pkg::IDX_ACC];
    alu_b = mem_val;
    if (logic_mem) begin
      alu_a = dir_val; // RQ11 RQ12
      alu_b = (mode_q == bada_pkg::MD_IMM) ? o2_q : sfr_q[bada_pkg::IDX_ACC];
    end else if (is_incdec) begin
      alu_a = mem_val; // RQ7 RQ8
    end else if (op_q == bada_pkg::OP_MUL || op_q == bada_pkg::OP_DIV) begin
      alu_b = sfr_q[bada_pkg::IDX_B]; // RQ19
    end
    mem_we = ex_fire && (logic_mem || (is_incdec && mode_q != bada_pkg::MD_ACC && mode_q != bada_pkg::MD_IMM));
    acc_we = ex_fire && !mem_we && op_q != bada_pkg::OP_INC_DATA_POINTER_16 && !(is_incdec && mode_q == bada_pkg::MD_IMM);
  end

  bada_alu u_alu (
    .op_i    (op_q),
    .a_i     (alu_a),
    .b_i     (alu_b),
    .cy_i    (sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_CY]),
    .ac_i    (sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_AC]),
    .res_o   (alu_res),
    .hi_o    (alu_hi),
    .hi_we_o (alu_hi_we),
    .cy_o    (alu_cy),
    .cy_we_o (alu_cy_we),
    .ac_o    (alu_ac),
    .ac_we_o (alu_ac_we),
    .ov_o    (alu_ov),
    .ov_we_o (alu_ov_we)
  );

  // bit address to byte address and current byte value
  always_comb begin
    bit_byte = bit_addr_i[7] ? {bit_addr_i[7:3], 3'b000} // RQ3
                             : bada_pkg::BIT_RAM_BASE + {4'h0, bit_addr_i[6:3]}; // RQ2
    bit_sx = bada_pkg::sfr_index(bit_byte);
    if (!bit_addr_i[7]) begin
      bit_byte_val = ram_q[bit_byte];
    end else if (!bit_sx[4]) begin
      bit_byte_val = 8'h00;
    end else if (bit_sx[3:0] == bada_pkg::IDX_PSW) begin
      bit_byte_val = {sfr_q[bada_pkg::IDX_PSW][7:1], par_q};
    end else begin
      bit_byte_val = sfr_q[bit_sx[3:0]];
    end
  end

  // shared write port: execution first, bit writes only while idle
  always_comb begin
    wr_en = 1'b0;
    wr_sfr = 1'b0;
    wr_addr = 8'h00;
    wr_data = alu_res;
    if (mem_we) begin
      wr_en = (mode_q != bada_pkg::MD_IND) || ind_ok;
      wr_sfr = (logic_mem || mode_q == bada_pkg::MD_DIR) && o1_q[7]; // RQ20
      case (mode_q)
        bada_pkg::MD_REG: wr_addr = logic_mem ? o1_q : rn_addr;
        bada_pkg::MD_IND: wr_addr = logic_mem ? o1_q : ptr;
        default: wr_addr = o1_q;
      endcase
    end else if (st_q == ST_IDLE && bit_we_i) begin
      wr_en = 1'b1; // RQ1
      wr_sfr = bit_addr_i[7];
      wr_addr = bit_byte;
      wr_data = bit_byte_val;
      wr_data[bit_addr_i[2:0]] = bit_val_i;
    end
    wr_sx = bada_pkg::sfr_index(wr_addr);
  end

  assign data_pointer_16_inc = {sfr_q[bada_pkg::IDX_DPH], sfr_q[bada_pkg::IDX_DPL]} + 16'h0001;

  // special function registers, accumulator, aux register, flags, pointer
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < bada_pkg::NSFR; i++) begin
        sfr_q[i] <= (i == int'(bada_pkg::IDX_P0) || i == int'(bada_pkg::IDX_P1) || i == int'(bada_pkg::IDX_P2)
                     || i == int'(bada_pkg::IDX_P3)) ? bada_pkg::PORT_RST : bada_pkg::SFR_RST;
      end
    end else begin
      if (wr_en && wr_sfr && wr_sx[4]) begin
        sfr_q[wr_sx[3:0]] <= wr_data;
      end
      if (acc_we) begin
        sfr_q[bada_pkg::IDX_ACC] <= alu_res;
      end
      if (ex_fire && alu_hi_we) begin
        sfr_q[bada_pkg::IDX_B] <= alu_hi; // RQ19
      end
      if (ex_fire && alu_cy_we) begin
        sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_CY] <= alu_cy; // RQ6 RQ16
      end
      if (ex_fire && alu_ac_we) begin
        sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_AC] <= alu_ac;
      end
      if (ex_fire && alu_ov_we) begin
        sfr_q[bada_pkg::IDX_PSW][bada_pkg::PSW_OV] <= alu_ov;
      end
      if (ex_fire && op_q == bada_pkg::OP_INC_DATA_POINTER_16) begin
        {sfr_q[bada_pkg::IDX_DPH], sfr_q[bada_pkg::IDX_DPL]} <= data_pointer_16_inc; // RQ9
      end
    end
  end

  // internal RAM, no reset
  always_ff @(posedge clk_i) begin
    if (wr_en && !wr_sfr && wr_addr <= bada_pkg::RAM_TOP) begin
      ram_q[wr_addr] <= wr_data;
    end
  end

  // parity of the accumulator, bit read data, cycle count helper
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_q <= 1'b0;
      bit_rd_q <= 1'b0;
      mcs_q <= 3'd0;
    end else begin
      par_q <= ^sfr_q[bada_pkg::IDX_ACC];
      if (bit_re_i) begin
        bit_rd_q <= bit_byte_val[bit_addr_i[2:0]]; // RQ1
      end
      if (start_ok) begin
        mcs_q <= 3'd0;
      end else if (st_q == ST_RUN && mc_en_q) begin
        mcs_q <= mcs_q + 3'd1;
      end
    end
  end

  // outputs, all from flip-flops
  assign busy_o = (st_q == ST_RUN);
  assign done_o = done_q;
  assign len_o = len_q;
  assign cyc_o = cyc_q;
  assign acc_o = sfr_q[bada_pkg::IDX_ACC];
  assign b_o = sfr_q[bada_pkg::IDX_B];
  assign psw_o = {sfr_q[bada_pkg::IDX_PSW][7:1], par_q};
  assign data_pointer_16_o = {sfr_q[bada_pkg::IDX_DPH], sfr_q[bada_pkg::IDX_DPL]};
  assign bit_rd_o = bit_rd_q;

  // checks
  property p_mc_period;
    @(posedge clk_i) disable iff (!rst_b_i)
    mc_en_q |=> (!mc_en_q)[*8] ##1 !mc_en_q ##1 !mc_en_q ##1 !mc_en_q ##1 mc_en_q;
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("machine cycle not 12 clocks"); // RQ4

  property p_data_pointer_16_len;
    @(posedge clk_i) disable iff (!rst_b_i)
    start_ok && op_i == bada_pkg::OP_INC_DATA_POINTER_16 |=> len_o == 2'd1 && cyc_o == 3'd2;
  endproperty
  a_data_pointer_16_len: assert property (p_data_pointer_16_len) else $error("pointer increment length wrong"); // RQ9

  property p_data_pointer_16_inc;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_q && op_q == bada_pkg::OP_INC_DATA_POINTER_16 |-> data_pointer_16_o == $past(data_pointer_16_o) + 16'h0001 && mcs_q == 3'd2;
  endproperty
  a_data_pointer_16_inc: assert property (p_data_pointer_16_inc) else $error("pointer increment wrong"); // RQ9

  property p_muldiv_cycles;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_q && (op_q == bada_pkg::OP_MUL || op_q == bada_pkg::OP_DIV) |-> mcs_q == 3'd4;
  endproperty
  a_muldiv_cycles: assert property (p_muldiv_cycles) else $error("multiply or divide not 4 cycles"); // RQ19

  property p_logic_imm_mem;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_q && dmem_q && mode_q == bada_pkg::MD_IMM && op_q == bada_pkg::OP_ANL |-> mcs_q == 3'd2 && len_o == 2'd3;
  endproperty
  a_logic_imm_mem: assert property (p_logic_imm_mem) else $error("logic into direct byte timing"); // RQ11

  property p_cpl;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_q && op_q == bada_pkg::OP_CPL |-> acc_o == ~$past(acc_o) && mcs_q == 3'd1;
  endproperty
  a_cpl: assert property (p_cpl) else $error("complement wrong"); // RQ15

  property p_rlc;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_q && op_q == bada_pkg::OP_RLC |-> {psw_o[7], acc_o} == {$past(acc_o), $past(psw_o[7])};
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate through carry wrong"); // RQ16

  property p_rr_swap;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_q && (op_q == bada_pkg::OP_RR || op_q == bada_pkg::OP_SWAP) |->
      acc_o == ((op_q == bada_pkg::OP_RR) ? {$past(acc_o[0]), $past(acc_o[7:1])}
                                          : {$past(acc_o[3:0]), $past(acc_o[7:4])});
  endproperty
  a_rr_swap: assert property (p_rr_swap) else $error("rotate right or swap wrong"); // RQ17 RQ18

  property p_bit_acc;
    @(posedge clk_i) disable iff (!rst_b_i)
    bit_re_i && bit_addr_i[7:3] == 5'h1c |=> bit_rd_o == $past(acc_o[bit_addr_i[2:0]]);
  endproperty
  a_bit_acc: assert property (p_bit_acc) else $error("register bit read wrong"); // RQ3

  property p_busy;
    @(posedge clk_i) disable iff (!rst_b_i)
    start_ok |=> busy_o ##[1:48] done_o;
  endproperty
  a_busy: assert property (p_busy) else $error("instruction did not finish"); // RQ4

  c_mul: cover property (@(posedge clk_i) disable iff (!rst_b_i) done_q && op_q == bada_pkg::OP_MUL);
  c_bitw: cover property (@(posedge clk_i) disable iff (!rst_b_i) bit_we_i && st_q == ST_IDLE);
  c_logic: cover property (@(posedge clk_i) disable iff (!rst_b_i) done_q && dmem_q);

endmodule

//--- rtl/bada_pkg.sv
package bada_pkg;

  // operations of the arithmetic and logic group
  typedef enum logic [4:0] {
    OP_ADD, OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_INC, OP_DEC, OP_INC_DATA_POINTER_16, OP_MUL, OP_DIV, OP_DA,
    OP_ANL, OP_ORL, OP_XRL, OP_CLR, OP_CPL, OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP
  } bada_op_t;

  // where the second operand (or the inc/dec target) comes from
  typedef enum logic [2:0] {MD_ACC, MD_REG, MD_DIR, MD_IND, MD_IMM} bada_mode_t;

  // timing: oscillator clocks per machine cycle
  localparam logic [3:0] MC_CLKS      = 4'h c;
  // memory map
  localparam int         RAM_BYTES    = 192;
  localparam logic [7:0] RAM_TOP      = 8'h bf;
  localparam logic [7:0] BIT_RAM_BASE = 8'h 20;
  localparam logic [7:0] ADDR_P0      = 8'h 80;
  localparam logic [7:0] ADDR_DPL     = 8'h 82;
  localparam logic [7:0] ADDR_DPH     = 8'h 83;
  localparam logic [7:0] ADDR_TIMER_CONTROL    = 8'h 88;
  localparam logic [7:0] ADDR_P1      = 8'h 90;
  localparam logic [7:0] ADDR_P2      = 8'h a0;
  localparam logic [7:0] ADDR_IE      = 8'h a8;
  localparam logic [7:0] ADDR_P3      = 8'h b0;
  localparam logic [7:0] ADDR_IP      = 8'h b8;
  localparam logic [7:0] ADDR_STS     = 8'h c8;
  localparam logic [7:0] ADDR_PSW     = 8'h d0;
  localparam logic [7:0] ADDR_SERIAL_FRAME_COUNTS    = 8'h d8;
  localparam logic [7:0] ADDR_ACC     = 8'h e0;
  localparam logic [7:0] ADDR_B       = 8'h f0;
  // storage slots of the special function registers
  localparam int         NSFR         = 14;
  localparam logic [3:0] IDX_P0 = 4'h0, IDX_DPL = 4'h1, IDX_DPH = 4'h2, IDX_TIMER_CONTROL = 4'h3;
  localparam logic [3:0] IDX_P1 = 4'h4, IDX_P2 = 4'h5, IDX_IE = 4'h6, IDX_P3 = 4'h7;
  localparam logic [3:0] IDX_IP = 4'h8, IDX_STS = 4'h9, IDX_PSW = 4'ha, IDX_SERIAL_FRAME_COUNTS = 4'hb;
  localparam logic [3:0] IDX_ACC = 4'hc, IDX_B = 4'hd;
  // status word fields
  localparam int PSW_CY = 7, PSW_AC = 6, PSW_RS1 = 4, PSW_RS0 = 3, PSW_OV = 2;
  // values after reset
  localparam logic [7:0] PORT_RST = 8'h ff;
  localparam logic [7:0] SFR_RST  = 8'h 00;

  // special function register slot: {valid, index}
  function automatic logic [4:0] sfr_index(input logic [7:0] addr);
    case (addr)
      ADDR_P0:   sfr_index = {1'b1, IDX_P0};
      ADDR_DPL:  sfr_index = {1'b1, IDX_DPL};
      ADDR_DPH:  sfr_index = {1'b1, IDX_DPH};
      ADDR_TIMER_CONTROL: sfr_index = {1'b1, IDX_TIMER_CONTROL};
      ADDR_P1:   sfr_index = {1'b1, IDX_P1};
      ADDR_P2:   sfr_index = {1'b1, IDX_P2};
      ADDR_IE:   sfr_index = {1'b1, IDX_IE};
      ADDR_P3:   sfr_index = {1'b1, IDX_P3};
      ADDR_IP:   sfr_index = {1'b1, IDX_IP};
      ADDR_STS:  sfr_index = {1'b1, IDX_STS};
      ADDR_PSW:  sfr_index = {1'b1, IDX_PSW};
      ADDR_SERIAL_FRAME_COUNTS: sfr_index = {1'b1, IDX_SERIAL_FRAME_COUNTS};
      ADDR_ACC:  sfr_index = {1'b1, IDX_ACC};
      ADDR_B:    sfr_index = {1'b1, IDX_B};
      default:   sfr_index = 5'h00;
    endcase
  endfunction

endpackage

//--- rtl/bada_alu.sv
// one-cycle combinational arithmetic and logic unit
module bada_alu (
  // operation and operands
  input  bada_pkg::bada_op_t op_i,
  input  logic [7:0]         a_i,
  input  logic [7:0]         b_i,
  input  logic               cy_i,
  input  logic               ac_i,
  // results
  output logic [7:0]         res_o,
  output logic [7:0]         hi_o,
  output logic               hi_we_o,
  output logic               cy_o,
  output logic               cy_we_o,
  output logic               ac_o,
  output logic               ac_we_o,
  output logic               ov_o,
  output logic               ov_we_o
);

  logic [8:0]  sum;
  logic [4:0]  lo;
  logic [15:0] prod;
  logic [8:0]  t;
  logic        cin;

  // result and flag selection per operation
  always_comb begin
    cin = (op_i == bada_pkg::OP_ADD_WITH_CARRY) ? cy_i : 1'b0;
    sum = 9'h000;
    lo = 5'h00;
    prod = {8'h00, a_i} * {8'h00, b_i};
    t = {1'b0, a_i};
    res_o = a_i;
    hi_o = b_i;
    hi_we_o = 1'b0;
    cy_o = cy_i;
    cy_we_o = 1'b0;
    ac_o = ac_i;
    ac_we_o = 1'b0;
    ov_o = 1'b0;
    ov_we_o = 1'b0;
    case (op_i)
      bada_pkg::OP_ADD, bada_pkg::OP_ADD_WITH_CARRY: begin
        lo = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin}; // RQ4 RQ5
        sum = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
        res_o = sum[7:0];
        {cy_o, ac_o, ov_o} = {sum[8], lo[4], (a_i[7] == b_i[7]) && (sum[7] != a_i[7])};
        {cy_we_o, ac_we_o, ov_we_o} = 3'b111;
      end
      bada_pkg::OP_SUBTRACT_WITH_BORROW: begin
        lo = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cy_i}; // RQ6
        sum = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cy_i};
        res_o = sum[7:0];
        {cy_o, ac_o, ov_o} = {sum[8], lo[4], (a_i[7] != b_i[7]) && (sum[7] != a_i[7])};
        {cy_we_o, ac_we_o, ov_we_o} = 3'b111;
      end
      bada_pkg::OP_INC: res_o = a_i + 8'h01; // RQ7
      bada_pkg::OP_DEC: res_o = a_i - 8'h01; // RQ8
      bada_pkg::OP_MUL: begin
        {hi_o, res_o} = prod; // RQ19
        {hi_we_o, cy_o, ov_o} = {1'b1, 1'b0, |prod[15:8]};
        {cy_we_o, ov_we_o} = 2'b11;
      end
      bada_pkg::OP_DIV: begin
        // a zero divisor flags overflow and leaves both registers alone
        if (b_i != 8'h00) begin
          res_o = a_i / b_i; // RQ19
          hi_o = a_i % b_i;
          hi_we_o = 1'b1;
        end
        {cy_o, ov_o} = {1'b0, b_i == 8'h00};
        {cy_we_o, ov_we_o} = 2'b11;
      end
      bada_pkg::OP_DA: begin
        if (t[3:0] > 4'h9 || ac_i) t = t + 9'h006; // RQ10
        if (t[7:4] > 4'h9 || t[8] || cy_i) t = t + 9'h060;
        res_o = t[7:0];
        cy_o = cy_i | t[8];
        cy_we_o = 1'b1;
      end
      bada_pkg::OP_ANL: res_o = a_i & b_i; // RQ11 RQ12
      bada_pkg::OP_ORL: res_o = a_i | b_i; // RQ13
      bada_pkg::OP_XRL: res_o = a_i ^ b_i; // RQ14
      bada_pkg::OP_CLR: res_o = 8'h00;
      bada_pkg::OP_CPL: res_o = ~a_i; // RQ15
      bada_pkg::OP_RL: res_o = {a_i[6:0], a_i[7]};
      bada_pkg::OP_RLC: begin
        {cy_o, res_o} = {a_i, cy_i}; // RQ16
        cy_we_o = 1'b1;
      end
      bada_pkg::OP_RR: res_o = {a_i[0], a_i[7:1]}; // RQ17
      bada_pkg::OP_RRC: begin
        {res_o, cy_o} = {cy_i, a_i};
        cy_we_o = 1'b1;
      end
      bada_pkg::OP_SWAP: res_o = {a_i[3:0], a_i[7:4]}; // RQ18
      default: res_o = a_i;
    endcase
  end

endmodule

//--- testbench/bit_addressed_alu_datapath_test.sv
module bit_addressed_alu_datapath_test;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus driven by the bench
  logic                 clk_i = 1'b0;
  logic                 rst_b_i = 1'b0;
  logic                 start_i = 1'b0;
  bada_pkg::bada_op_t   op_i = bada_pkg::OP_CLR;
  bada_pkg::bada_mode_t mode_i = bada_pkg::MD_ACC;
  logic                 dst_mem_i = 1'b0;
  logic [7:0]           opnd1_i = 8'h00;
  logic [7:0]           opnd2_i = 8'h00;
  logic                 bit_re_i = 1'b0;
  logic                 bit_we_i = 1'b0;
  logic [7:0]           bit_addr_i = 8'h00;
  logic                 bit_val_i = 1'b0;
  // observed outputs
  logic                 busy_o;
  logic                 done_o;
  logic [1:0]           len_o;
  logic [2:0]           cyc_o;
  logic [7:0]           acc_o;
  logic [7:0]           b_o;
  logic [7:0]           psw_o;
  logic [15:0]          data_pointer_16_o;
  logic                 bit_rd_o;
  // expectations and bookkeeping
  logic [7:0]           ea;
  logic [7:0]           eb;
  logic                 ec;
  logic [15:0]          ed;
  logic [31:0]          x;
  logic [6:0]           k;
  int                   seed = 84844;
  int                   n_mismatch = 0;
  int                   checks_done = 0;
  bada_pkg::bada_op_t   ops [10] = '{bada_pkg::OP_CLR, bada_pkg::OP_CPL, bada_pkg::OP_RL, bada_pkg::OP_RLC,
                                     bada_pkg::OP_RR, bada_pkg::OP_RRC, bada_pkg::OP_SWAP,
                                     bada_pkg::OP_ANL, bada_pkg::OP_ORL, bada_pkg::OP_XRL};

  bada_core DUT (.reg_sel_i(3'h0), .*);

  // free running 100 MHz clock
  always #5 clk_i = ~clk_i;

  // accumulator-only operations on {carry, accumulator}
  function automatic logic [8:0] f(input bada_pkg::bada_op_t op, input logic [8:0] v);
    case (op)
      bada_pkg::OP_CLR: f = {v[8], 8'h00};
      bada_pkg::OP_CPL: f = {v[8], ~v[7:0]};
      bada_pkg::OP_RL:  f = {v[8], v[6:0], v[7]};
      bada_pkg::OP_RLC: f = {v[7:0], v[8]};
      bada_pkg::OP_RR:  f = {v[8], v[0], v[7:1]};
      bada_pkg::OP_RRC: f = {v[0], v[8], v[7:1]};
      default:          f = {v[8], v[3:0], v[7:4]};
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // issue one instruction, wait for done, check byte count, cycles and latency
  task automatic run(input bada_pkg::bada_op_t op, input bada_pkg::bada_mode_t md, input logic dm,
                     input logic [7:0] a1, input logic [7:0] a2, input logic [4:0] lc);
    int n;
    n = 0;
    op_i <= op;
    mode_i <= md;
    dst_mem_i <= dm;
    opnd1_i <= a1;
    opnd2_i <= a2;
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_o !== 1'b1 && n < 60);
    check({10'h000, busy_o, len_o, cyc_o}, {11'h000, lc});
    check(16'(n >= 12 * lc[2:0] - 10 && n <= 12 * lc[2:0] + 1), 16'h0001);
  endtask

  // write one bit through the bit-address port, then read it back
  task automatic bw(input logic [7:0] a, input logic v);
    bit_addr_i <= a;
    bit_val_i <= v;
    bit_we_i <= 1'b1;
    @(posedge clk_i);
    bit_we_i <= 1'b0;
    bit_re_i <= 1'b1;
    @(posedge clk_i);
    bit_re_i <= 1'b0;
    @(posedge clk_i);
    check({15'h0000, bit_rd_o}, {15'h0000, v});
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // main sequence: reset, random rounds, fixed corner cases
  initial begin
    repeat (10) @(posedge clk_i);
    check({b_o, acc_o}, 16'h0000);
    check(data_pointer_16_o, 16'h0000);
    check({busy_o, done_o, len_o, cyc_o, bit_rd_o, psw_o}, 16'h0000);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    ea = 8'h00;
    eb = 8'h00;
    ed = 16'h0000;
    run(bada_pkg::OP_ORL, bada_pkg::MD_DIR, 1'b0, 8'h90, 8'h00, 5'h11);
    check({b_o, acc_o}, 16'h00ff);
    ea = 8'hff;
    for (int i = 0; i < 8; i++) begin
      x = $random(seed);
      eb = x[31:24] ^ x[7:0];
      for (int j = 0; j < 8; j++) begin
        bw({5'h1e, j[2:0]}, eb[j]);
      end
      bw(8'hd7, x[8]);
      {ec, ea} = {1'b0, ea} + {1'b0, x[7:0]} + 9'(x[8]);
      run(bada_pkg::OP_ADD_WITH_CARRY, bada_pkg::MD_IMM, 1'b0, x[7:0], 8'h00, 5'h11);
      check({psw_o[7], 7'h00, acc_o}, {ec, 7'h00, ea});
      {ec, ea} = {1'b0, ea} - {1'b0, eb} - {8'h00, ec};
      run(bada_pkg::OP_SUBTRACT_WITH_BORROW, bada_pkg::MD_DIR, 1'b0, 8'hf0, 8'h00, 5'h11);
      check({psw_o[7], 7'h00, acc_o}, {ec, 7'h00, ea});
      {eb, ea} = ea * eb;
      run(bada_pkg::OP_MUL, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h0c);
      check({b_o, acc_o}, {eb, ea});
      ec = (eb == 8'h00);
      if (eb != 8'h00) begin
        {eb, ea} = {ea % eb, ea / eb};
      end
      run(bada_pkg::OP_DIV, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h0c);
      check({b_o, acc_o}, {eb, ea});
      check({15'h0000, psw_o[2]}, {15'h0000, ec});
      ec = 1'b0;
      {ec, ea} = f(ops[i % 7], {ec, ea});
      run(ops[i % 7], bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h09);
      check({psw_o[7], 7'h00, acc_o}, {ec, 7'h00, ea});
      ea = ea + 8'h01;
      run(bada_pkg::OP_INC, bada_pkg::MD_DIR, 1'b0, 8'he0, 8'h00, 5'h11);
      ed = ed + 16'h0001;
      run(bada_pkg::OP_INC_DATA_POINTER_16, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h0a);
      check(data_pointer_16_o, ed);
      ea = ea ^ x[23:16];
      run(bada_pkg::OP_XRL, bada_pkg::MD_IMM, 1'b0, x[23:16], 8'h00, 5'h11);
      check({b_o, acc_o}, {eb, ea});
      case (i % 3)
        0: eb = eb & x[15:8];
        1: eb = eb | x[15:8];
        default: eb = eb ^ x[15:8];
      endcase
      run(ops[7 + i % 3], bada_pkg::MD_IMM, 1'b1, 8'hf0, x[15:8], 5'h1a);
      check({b_o, acc_o}, {eb, ea});
      k = x[30:24];
      run(bada_pkg::OP_CLR, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h09);
      run(bada_pkg::OP_ANL, bada_pkg::MD_ACC, 1'b1, {4'h2, k[6:3]}, 8'h00, 5'h11);
      bw({1'b0, k}, 1'b1);
      run(bada_pkg::OP_ORL, bada_pkg::MD_DIR, 1'b0, {4'h2, k[6:3]}, 8'h00, 5'h11);
      ea = 8'h01 << k[2:0];
      check({b_o, acc_o}, {eb, ea});
    end
    run(bada_pkg::OP_CLR, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h09);
    run(bada_pkg::OP_ADD, bada_pkg::MD_IMM, 1'b0, 8'h15, 8'h00, 5'h11);
    run(bada_pkg::OP_ADD, bada_pkg::MD_IMM, 1'b0, 8'h27, 8'h00, 5'h11);
    run(bada_pkg::OP_DA, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h09);
    check({b_o, acc_o}, {eb, 8'h42});
    // pointer register zero is cleared, then decremented through itself
    run(bada_pkg::OP_CLR, bada_pkg::MD_ACC, 1'b0, 8'h00, 8'h00, 5'h09);
    run(bada_pkg::OP_ANL, bada_pkg::MD_ACC, 1'b1, 8'h00, 8'h00, 5'h11);
    run(bada_pkg::OP_DEC, bada_pkg::MD_IND, 1'b0, 8'h00, 8'h00, 5'h09);
    run(bada_pkg::OP_ORL, bada_pkg::MD_DIR, 1'b0, 8'h00, 8'h00, 5'h11);
    check({b_o, acc_o}, {eb, 8'hff});
    tally_and_finish;
  end

  // watchdog against a hung handshake
  initial begin
    #100_000;
    n_mismatch++;
    tally_and_finish;
  end
endmodule
